// *** dv/rtc_calendar_alarm_core_bench.sv ***
`timescale 1ns/1ps
module rtc_calendar_alarm_core_bench;
   import rtc_pkg::*;
   localparam int NV       = 50;                        // short write time
   localparam int TICK_TAP = 3;                         // a second lasts 256 clocks here
   localparam int ELO[4]   = '{0, 9, 19, 150};          // pin edges in 1280 cycles
   localparam int EHI[4]   = '{0, 11, 21, 170};
   localparam int CY[6]    = '{24, 24, 23, 0, 99, 23};  // rollover corners: year,
   localparam int CM[6]    = '{2, 2, 2, 2, 12, 4};      // month
   localparam int CD[6]    = '{28, 29, 28, 28, 31, 30}; // and day loaded: a month end, or 28 in a leap february
   logic                         clk, reset_n, xtal_clk, time_load, pin, prev, ok;
   logic [8*NUM_FIELDS-1:0]      tl_val, t_val, tv;
   logic [1:0][8*NUM_FIELDS-1:0] al_val;
   logic [1:0][NUM_FIELDS-1:0]   al_en;
   logic [1:0]                   arm, rpt, ien, clr, flag, fsel, exp;
   logic                         pin_o, pin_oe, mem_wr, busy;
   logic [MEM_AW-1:0]            wa, ra, adr;
   logic [7:0]                   wd, rd, dat;
   logic [2:0]                   wp;
   logic [31:0]                  rnd_q;
   int                           err_total, cmp_count, n, s, a, y, mo, dy, w;

   assign pin = pin_oe ? pin_o : 1'b1;         // pull-up holds a released pin high

   rtc_calendar_alarm_core #(.NV_CYCLES(NV), .SEC_TAP(TICK_TAP)) dut_u (
      .clk, .reset_n, .xtal_clk, .time_load, .time_load_value(tl_val), .time_value(t_val),
      .alarm_value(al_val), .alarm_field_en(al_en), .alarm_arm(arm), .alarm_repeat(rpt),
      .alarm_int_en(ien), .alarm_flag_clr(clr), .alarm_flag(flag), .freq_sel(fsel),
      .alarm_or_freq_pin_i(pin), .alarm_or_freq_pin_o(pin_o), .alarm_or_freq_pin_oe(pin_oe),
      .mem_wr, .mem_wr_addr(wa), .mem_wr_data(wd), .wp_mode(wp), .mem_rd_addr(ra),
      .mem_rd_data(rd), .nv_busy(busy));
   rtc_host_model #(.NV_CYCLES(NV)) host_u (
      .clk, .nv_busy(busy), .mem_wr, .mem_wr_addr(wa), .mem_wr_data(wd));

   // ******************
   // clocks and helpers
   // ******************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      xtal_clk = 1'b0;                         // crystal, unrelated in phase
      #37;
      forever #80 xtal_clk = ~xtal_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [7:0] bcd(input int v);
      bcd = 8'((v / 10) * 16 + v % 10);
   endfunction
   function automatic logic [55:0] stamp(input int wd, input int yr, input int mn, input int dt,
                                         input int hr, input int mi, input int se);
      stamp = {bcd(wd), bcd(yr), bcd(mn), bcd(dt), bcd(hr), bcd(mi), bcd(se)};
   endfunction
   // midnight after the given day, from the calendar rules alone
   function automatic logic [55:0] next_day(input int wd, input int yr, input int mn,
                                            input int dt);
      int last;
      if (mn == 2)
         last = (yr % 4 == 0) ? 29 : 28;
      else if (mn == 4 || mn == 6 || mn == 9 || mn == 11)
         last = 30;
      else
         last = 31;
      if (dt < last)
         next_day = stamp((wd + 1) % 7, yr, mn, dt + 1, 0, 0, 0);
      else if (mn < 12)
         next_day = stamp((wd + 1) % 7, yr, mn + 1, 1, 0, 0, 0);
      else
         next_day = stamp((wd + 1) % 7, (yr + 1) % 100, 1, 1, 0, 0, 0);
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // random valid calendar, seconds given
   task automatic roll(input int sec);
      rnd_q = lfsr(rnd_q);
      tv = {bcd(rnd_q % 7), bcd(rnd_q[7:0] % 100), bcd(1 + rnd_q[11:8] % 12),
            bcd(1 + rnd_q[16:12] % 28), bcd(rnd_q[20:16] % 24), bcd(rnd_q[26:21] % 60),
            bcd(sec)};
   endtask
   task automatic load(input logic [8*NUM_FIELDS-1:0] v);
      tl_val = v;
      time_load = 1'b1;
      step(1);
      time_load = 1'b0;
      check(t_val, v);
      step(3);
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      conclude();
   end

   // ******************
   // main sequence
   // ******************
   initial
   begin
      {time_load, tl_val, al_val, al_en, arm, rpt, ien, clr, ra, wp} = '0;
      fsel = FSEL_IRQ;
      reset_n = 1'b0;
      rnd_q = 32'had292e39;
      step(16);
      reset_n = 1'b1;
      check(t_val, 56'h00_00_01_01_00_00_00);
      check(pin, 1'b1);
      step(48);                                // crystal side leaves reset a few edges later
      // both alarms, one shot and repeat, interrupt on and off
      for (int k = 0; k < 4; k++)
      begin
         a = k % 2;
         s = int'(lfsr(rnd_q) % 59);
         roll(s);
         al_val[a] = tv;
         al_en[a] = 7'(rnd_q) | 7'h01;
         rpt[a] = k[1];
         ien[a] = (k != 1);
         arm[a] = 1'b1;
         step(1);
         arm[a] = 1'b0;
         tv[7:0] = bcd(s + 1);
         load(tv);
         check(flag, 2'h0);
         tv[7:0] = bcd(s);
         load(tv);
         exp = 2'(1 << a);
         check(flag, exp);
         check(pin, !ien[a]);
         clr = exp;
         step(1);
         clr = 2'h0;
         step(2);
         check(pin, 1'b1);
         load(tv);
         check(flag, rpt[a] ? exp : 2'h0);
         clr = exp;
         al_en[a] = '0;
         step(3);
         clr = 2'h0;
      end
      // midnight rollovers: leap and common february, month and year ends
      for (int k = 0; k < 10; k++)
      begin
         rnd_q = lfsr(rnd_q);
         w = int'(rnd_q[31:24] % 7);
         if (k < 6)
         begin
            y  = CY[k];
            mo = CM[k];
            dy = CD[k];
         end
         else
         begin
            y  = int'(rnd_q[6:0] % 100);
            mo = 1 + int'(rnd_q[11:8] % 12);
            dy = 1 + int'(rnd_q[16:12] % 28);
         end
         load(stamp(w, y, mo, dy, 23, 59, 59));
         n = 0;
         while (t_val[7:0] == 8'h59 && n < 600)
         begin
            step(1);
            n++;
         end
         check(t_val, next_day(w, y, mo, dy));
      end
      // square wave selections, edges counted at the pin
      for (int m = 1; m < 4; m++)
      begin
         fsel = 2'(m);
         step(20);
         n = 0;
         repeat (1280)
         begin
            prev = pin;
            step(1);
            n += int'(pin != prev);
         end
         check(n >= ELO[m] && n <= EHI[m], 1'b1);
      end
      fsel = FSEL_IRQ;
      step(3);
      check(pin, 1'b1);
      // every guard mode, then the edge of mode 7
      for (int m = 0; m < WP_MODES + 2; m++)
      begin
         rnd_q = lfsr(rnd_q);
         wp = (m < WP_MODES) ? 3'(m) : 3'h7;
         adr = (m < WP_MODES) ? rnd_q[MEM_AW-1:0] : 9'(9'h1b7 + m);
         dat = rnd_q[31:24];
         host_u.write_byte(adr, dat, m == 0, ok);
         check(ok, !(adr >= WP_LO[wp] && adr <= WP_HI[wp]));
         ra = adr;
         step(2);
         if (ok === 1'b1)
            check(rd, dat);
      end
      conclude();
   end
endmodule

// *** dv/rtc_calendar_alarm_core_chk.sv ***
`timescale 1ns/1ps
// ******************
// port checker
// ******************
module rtc_calendar_alarm_core_chk
   import rtc_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES
)
(
   input wire logic                       clk,
   input wire logic                       reset_n,
   input wire logic                       time_load,
   input wire logic [8*NUM_FIELDS-1:0]    time_load_value,
   input wire logic [8*NUM_FIELDS-1:0]    time_value,
   input wire logic [1:0][NUM_FIELDS-1:0] alarm_field_en,
   input wire logic [1:0]                 alarm_int_en,
   input wire logic [1:0]                 alarm_flag_clr,
   input wire logic [1:0]                 alarm_flag,
   input wire logic [1:0]                 freq_sel,
   input wire logic                       alarm_or_freq_pin_o,
   input wire logic                       alarm_or_freq_pin_oe,
   input wire logic                       mem_wr,
   input wire logic [MEM_AW-1:0]          mem_wr_addr,
   input wire logic [2:0]                 wp_mode,
   input wire logic                       nv_busy
);
   logic [31:0] busy_cnt_q;   // cycles of the running write
   wire         irq_w   = |(alarm_flag & alarm_int_en);
   wire         guard_w = mem_wr_addr >= WP_LO[wp_mode] && mem_wr_addr <= WP_HI[wp_mode];

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // restarts in reset, so a write cut short never counts
   always_ff @(posedge clk)
      busy_cnt_q <= (reset_n && nv_busy) ? busy_cnt_q + 32'h1 : 32'h0;

   load_take_a: assert property (time_load |=> time_value == $past(time_load_value))
      else $error("time load not taken");
   nv_len_a: assert property ($fell(nv_busy) && $past(reset_n) |-> busy_cnt_q == NV_CYCLES)
      else $error("write cycle length wrong");
   nv_start_a: assert property (mem_wr && !nv_busy && !guard_w |=> nv_busy)
      else $error("write did not start");
   nv_prot_a: assert property (mem_wr && !nv_busy && guard_w |=> !nv_busy)
      else $error("guarded write started");
   flag_clr_a: assert property ($past(reset_n) |-> ($past(alarm_flag) & ~alarm_flag &
      ~$past(alarm_flag_clr)) == 2'h0) else $error("flag dropped without clear");
   flag_cause_a: assert property ($rose(alarm_flag[1]) |-> $past(alarm_field_en[1], 2) != '0)
      else $error("flag with no field enabled");
   pin_low_a: assert property (alarm_or_freq_pin_o == 1'b0)
      else $error("pin driven high");
   irq_pin_a: assert property ($past(reset_n) && $past(freq_sel) == FSEL_IRQ
      |-> alarm_or_freq_pin_oe == $past(irq_w)) else $error("interrupt pin wrong");

   cover property ($rose(alarm_flag[0]));
   cover property ($fell(nv_busy));
   cover property (time_value[39:24] == 16'h0229);
   cover property (freq_sel == FSEL_32KHZ && $rose(alarm_or_freq_pin_oe));
endmodule

bind rtc_calendar_alarm_core rtc_calendar_alarm_core_chk #(.NV_CYCLES(NV_CYCLES)) chk_u (
   .clk, .reset_n, .time_load, .time_load_value, .time_value, .alarm_field_en,
   .alarm_int_en, .alarm_flag_clr, .alarm_flag, .freq_sel, .alarm_or_freq_pin_o,
   .alarm_or_freq_pin_oe, .mem_wr, .mem_wr_addr, .wp_mode, .nv_busy);

// *** dv/rtc_host_model.sv ***
`timescale 1ns/1ps
// ******************
// host side writer
// ******************
module rtc_host_model
   import rtc_pkg::*;
#(
   parameter int NV_CYCLES = 50
)
(
   input  wire logic         clk,
   input  wire logic         nv_busy,
   output logic              mem_wr,
   output logic [MEM_AW-1:0] mem_wr_addr,
   output logic [7:0]        mem_wr_data
);
   initial
   begin
      mem_wr      = 1'b0;
      mem_wr_addr = '0;
      mem_wr_data = 8'h00;
   end

   // one byte write; hurry breaks the wait on purpose
   task automatic write_byte(input logic [MEM_AW-1:0] a, input logic [7:0] d,
                             input logic hurry, output logic started);
      int n;
      mem_wr_addr = a;
      mem_wr_data = d;
      mem_wr      = 1'b1;
      @(posedge clk);
      #1 mem_wr   = 1'b0;
      mem_wr_data = ~d;    // released data never shows the last value
      @(posedge clk);
      #1 started  = nv_busy;
      if (hurry && started)
      begin
         mem_wr = 1'b1;    // a write inside the busy time, must be dropped
         @(posedge clk);
         #1 mem_wr = 1'b0;
      end
      n = 0;
      while (nv_busy && n < NV_CYCLES + 8)
      begin
         @(posedge clk);
         #1 n++;
      end
   endtask
endmodule

// *** rtl/bcd_cnt_if.sv ***
`timescale 1ns/1ps
// one bcd counter's control and state between calendar and counter
interface bcd_cnt_if;
   logic       inc;        // advance by one
   logic       load;       // take load_val
   logic [7:0] load_val;   // new bcd value
   logic [7:0] lo;         // wrap target
   logic [7:0] hi;         // last value before wrap
   logic [7:0] val;        // current bcd value
   logic       at_max;     // val equals hi

   modport ctrl (output inc, output load, output load_val, output lo, output hi,
                 input val, input at_max);
   modport cnt  (input inc, input load, input load_val, input lo, input hi,
                 output val, output at_max);
endinterface

// *** rtl/bcd_counter.sv ***
`timescale 1ns/1ps
// one bcd field counter with programmable wrap range
module bcd_counter
   import rtc_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00
)
(
   input  wire logic clk,
   input  wire logic reset_n,
   bcd_cnt_if.cnt    port_i
);

   // ************************************************************
   // counter state
   // ************************************************************
   logic [7:0] val_q;   // current value
   logic [7:0] val_d;   // next value
   wire        wrap;    // increment rolls over

   assign wrap          = (val_q == port_i.hi);
   assign port_i.val    = val_q;
   assign port_i.at_max = wrap;

   // load wins over increment so a set time is never skewed
   always_comb
   begin
      val_d = val_q;
      if (port_i.load)
         val_d = port_i.load_val;
      else if (port_i.inc)
         val_d = wrap ? port_i.lo : bcd_inc(val_q);
   end

   // register, synchronous reset
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         val_q <= RESET_VAL;
      else
         val_q <= val_d;
   end

endmodule

// *** rtl/rtc_calendar_alarm_core.sv ***
`timescale 1ns/1ps
// Operation
// - leap day inserted automatically through 2099
// - separate time and calendar counters, each readable
// - two independent alarms compare selected fields
// - match sets status flag, optionally interrupt
// - pulse mode makes alarm recur on matches
// - pin gives 1Hz, 4096Hz, 32768Hz or the interrupt
// - self-timed nonvolatile write; host waits 20 ms
// - 4k bit memory, eight protection modes
// - frequency select picks interrupt or square wave
// - interrupt drives pin low only, open drain
// - all time and calendar counters held in packed bcd
module rtc_calendar_alarm_core
   import rtc_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYCLES,
   parameter int SEC_TAP   = TAP_1HZ   // divider bit whose rise marks one second
)
(
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    xtal_clk,
   input  wire logic                    time_load,
   input  wire logic [8*NUM_FIELDS-1:0] time_load_value,
   output logic      [8*NUM_FIELDS-1:0] time_value,
   input  wire logic [1:0][8*NUM_FIELDS-1:0] alarm_value,
   input  wire logic [1:0][NUM_FIELDS-1:0]   alarm_field_en,
   input  wire logic [1:0]              alarm_arm,
   input  wire logic [1:0]              alarm_repeat,
   input  wire logic [1:0]              alarm_int_en,
   input  wire logic [1:0]              alarm_flag_clr,
   output logic      [1:0]              alarm_flag,
   input  wire logic [1:0]              freq_sel,
   input  wire logic                    alarm_or_freq_pin_i,
   output logic                         alarm_or_freq_pin_o,
   output logic                         alarm_or_freq_pin_oe,
   input  wire logic                    mem_wr,
   input  wire logic [MEM_AW-1:0]       mem_wr_addr,
   input  wire logic [7:0]              mem_wr_data,
   input  wire logic [2:0]              wp_mode,
   input  wire logic [MEM_AW-1:0]       mem_rd_addr,
   output logic      [7:0]              mem_rd_data,
   output logic                         nv_busy
);

   // ************************************************************
   // crystal domain: free divider and its reset
   // ************************************************************
   logic [1:0]            xrst_sync_q;   // reset carried into crystal domain
   logic [XTAL_DIV_W-1:0] xdiv_q;        // crystal divider

   // reset is caught twice on the crystal clock before it acts
   always_ff @(posedge xtal_clk)
   begin
      xrst_sync_q <= {xrst_sync_q[0], reset_n};
   end

   // divider runs on the crystal; taps leave as levels
   always_ff @(posedge xtal_clk)
   begin
      if (!xrst_sync_q[1])
         xdiv_q <= '0;
      else
         xdiv_q <= xdiv_q + 1'b1;
   end

   // ************************************************************
   // crossing into the system clock
   // ************************************************************
   logic [1:0] s1hz_q;      // 1 Hz level synchroniser
   logic [1:0] s4k_q;       // 4096 Hz level synchroniser
   logic [1:0] s32k_q;      // crystal level synchroniser
   logic       s1hz_dly_q;  // previous synchronised 1 Hz level
   logic       pin_in_q;    // pin readback, first stage
   logic       pin_in_s_q;  // pin readback, second stage, unused by logic

   // two stages each; only the second stage is looked at, except the pin readback, which no logic looks at
   always_ff @(posedge clk)
   begin
      s1hz_q     <= {s1hz_q[0], xdiv_q[SEC_TAP]};
      s4k_q      <= {s4k_q[0], xdiv_q[TAP_4KHZ]};
      s32k_q     <= {s32k_q[0], xtal_clk};
      s1hz_dly_q <= s1hz_q[1];
      pin_in_q   <= alarm_or_freq_pin_i;
      pin_in_s_q <= pin_in_q;
   end

   wire sec_tick = s1hz_q[1] & ~s1hz_dly_q;   // one pulse per second

   // ************************************************************
   // calendar counters
   // ************************************************************
   bcd_cnt_if cnt [NUM_FIELDS] ();

   logic [7:0] fval [NUM_FIELDS];   // current bcd values
   logic       fmax [NUM_FIELDS];   // at upper limit
   logic       finc [NUM_FIELDS];   // increment per field

   wire        leap      = leap_year(fval[F_YEAR]);
   wire  [7:0] month_end = days_in_month(fval[F_MONTH], leap);

   // carry chain: seconds to years, weekday steps with the date
   assign finc[F_SEC]   = sec_tick;
   assign finc[F_MIN]   = finc[F_SEC] & fmax[F_SEC];
   assign finc[F_HOUR]  = finc[F_MIN] & fmax[F_MIN];
   assign finc[F_DATE]  = finc[F_HOUR] & fmax[F_HOUR];
   assign finc[F_MONTH] = finc[F_DATE] & fmax[F_DATE];
   assign finc[F_YEAR]  = finc[F_MONTH] & fmax[F_MONTH];
   assign finc[F_DOW]   = finc[F_DATE];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FIELDS; gi++)
      begin : g_field
         assign cnt[gi].inc      = finc[gi];
         assign cnt[gi].load     = time_load;
         assign cnt[gi].load_val = time_load_value[8*gi +: 8];
         assign cnt[gi].lo       = FIELD_LO[gi];
         assign cnt[gi].hi       = (gi == F_DATE) ? month_end : FIELD_HI[gi];
         assign fval[gi]         = cnt[gi].val;
         assign fmax[gi]         = cnt[gi].at_max;

         // one counter per field keeps every field readable on its own
         bcd_counter #(
            .RESET_VAL (FIELD_LO[gi])
         ) u_cnt (
            .clk     (clk),
            .reset_n (reset_n),
            .port_i  (cnt[gi])
         );

         // exported value comes straight from the counter flops
         assign time_value[8*gi +: 8] = fval[gi];
      end
   endgenerate

   // ************************************************************
   // alarms
   // ************************************************************
   logic       tick_dly_q;   // compare one cycle after counters move
   logic [1:0] armed_q;      // alarm still allowed to fire
   logic [1:0] flag_q;       // sticky match flags
   logic [1:0] match;        // selected fields agree
   logic [1:0] fire;         // match on a new second or after a time load

   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_alarm
         logic [NUM_FIELDS-1:0] eq;   // per-field equality, masked
         for (genvar fj = 0; fj < NUM_FIELDS; fj++)
         begin : g_cmp
            assign eq[fj] = ~alarm_field_en[gi][fj] |
                            (alarm_value[gi][8*fj +: 8] == fval[fj]);
         end
         // no field selected means no match, not match-always
         assign match[gi] = armed_q[gi] & (|alarm_field_en[gi]) & (&eq);
         assign fire[gi]  = tick_dly_q & match[gi];
      end
   endgenerate

   // arm, one-shot disarm, sticky flags; a new match beats a clear
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         tick_dly_q <= 1'b0;
         armed_q    <= 2'h0;
         flag_q     <= 2'h0;
      end
      else
      begin
         tick_dly_q <= sec_tick | time_load;
         armed_q    <= alarm_arm | (armed_q & ~(fire & ~alarm_repeat));
         flag_q     <= fire | (flag_q & ~alarm_flag_clr);
      end
   end

   assign alarm_flag = flag_q;

   // ************************************************************
   // shared open-drain pin
   // ************************************************************
   logic pin_oe_q;   // pulling low
   logic pin_oe_d;

   wire irq_req = |(flag_q & alarm_int_en);

   // square wave is made by pulling low during its low half
   always_comb
   begin
      case (freq_sel)
         FSEL_IRQ:   pin_oe_d = irq_req;
         FSEL_1HZ:   pin_oe_d = ~s1hz_q[1];
         FSEL_4KHZ:  pin_oe_d = ~s4k_q[1];
         FSEL_32KHZ: pin_oe_d = ~s32k_q[1];
         default:    pin_oe_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         pin_oe_q <= 1'b0;
      else
         pin_oe_q <= pin_oe_d;
   end

   assign alarm_or_freq_pin_oe = pin_oe_q;
   assign alarm_or_freq_pin_o  = 1'b0;

   // ************************************************************
   // user memory with timed nonvolatile write
   // ************************************************************
   logic [7:0]          mem [MEM_DEPTH];   // 4k bit array
   logic [NV_CNT_W-1:0] nv_cnt_q;          // write cycle countdown
   logic [MEM_AW-1:0]   wr_addr_q;         // pending write address
   logic [7:0]          wr_data_q;         // pending write data
   logic                busy_q;
   logic [7:0]          rd_q;

   wire in_window = (mem_wr_addr >= WP_LO[wp_mode]) &&
                    (mem_wr_addr <= WP_HI[wp_mode]);
   // writes during a cycle or into a guarded window are dropped
   wire accept    = mem_wr & ~busy_q & ~in_window;
   wire nv_done   = busy_q & (nv_cnt_q == '0);

   // countdown from the stop; the cell changes only at the end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         busy_q    <= 1'b0;
         nv_cnt_q  <= '0;
         wr_addr_q <= '0;
         wr_data_q <= 8'h00;
      end
      else if (accept)
      begin
         busy_q    <= 1'b1;
         nv_cnt_q  <= NV_CNT_W'(NV_CYCLES - 1);
         wr_addr_q <= mem_wr_addr;
         wr_data_q <= mem_wr_data;
      end
      else if (nv_done)
         busy_q    <= 1'b0;
      else if (busy_q)
         nv_cnt_q  <= nv_cnt_q - 1'b1;
   end

   // array has no reset; contents persist like nonvolatile cells
   always_ff @(posedge clk)
   begin
      if (nv_done)
         mem[wr_addr_q] <= wr_data_q;
      rd_q <= mem[mem_rd_addr];
   end

   assign mem_rd_data = rd_q;
   assign nv_busy     = busy_q;

endmodule

// *** rtl/rtc_pkg.sv ***
package rtc_pkg;

   // ************************************************************
   // field indices of the time and calendar counters
   // ************************************************************
   localparam int NUM_FIELDS = 7;
   localparam int F_SEC      = 0;
   localparam int F_MIN      = 1;
   localparam int F_HOUR     = 2;
   localparam int F_DATE     = 3;
   localparam int F_MONTH    = 4;
   localparam int F_YEAR     = 5;
   localparam int F_DOW      = 6;

   // bcd lower and upper limits per field (date upper comes from the month)
   localparam logic [7:0] FIELD_LO [NUM_FIELDS] = '{8'h00, 8'h00, 8'h00, 8'h01,
                                                     8'h01, 8'h00, 8'h00};
   localparam logic [7:0] FIELD_HI [NUM_FIELDS] = '{8'h59, 8'h59, 8'h23, 8'h31,
                                                     8'h12, 8'h99, 8'h06};

   // ************************************************************
   // square wave selection on the shared pin
   // ************************************************************
   localparam logic [1:0] FSEL_IRQ   = 2'h0;   // interrupt function, else released
   localparam logic [1:0] FSEL_1HZ   = 2'h1;
   localparam logic [1:0] FSEL_4KHZ  = 2'h2;
   localparam logic [1:0] FSEL_32KHZ = 2'h3;

   // crystal divider taps: bit n toggles at xtal / 2^(n+1)
   localparam int XTAL_DIV_W = 15;
   localparam int TAP_4KHZ   = 2;
   localparam int TAP_1HZ    = 14;

   // ************************************************************
   // non-volatile write timing and memory
   // ************************************************************
   localparam int CLK_HZ          = 100_000_000;
   localparam int NV_WRITE_MS     = 20;
   localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);
   localparam int NV_CNT_W        = 22;
   localparam int MEM_DEPTH       = 512;
   localparam int MEM_AW          = 9;
   localparam int WP_MODES        = 8;

   // protected window per mode; lo above hi means nothing is guarded
   localparam logic [8:0] WP_LO [WP_MODES] = '{9'h1ff, 9'h180, 9'h100, 9'h000,
                                                9'h000, 9'h000, 9'h000, 9'h1c0};
   localparam logic [8:0] WP_HI [WP_MODES] = '{9'h000, 9'h1ff, 9'h1ff, 9'h1ff,
                                                9'h07f, 9'h0ff, 9'h03f, 9'h1ff};

   // ************************************************************
   // bcd helpers
   // ************************************************************
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
   endfunction

   // years 2000..2099: every multiple of four is a leap year
   function automatic logic leap_year(input logic [7:0] y);
      if (y[4] == 1'b0)
         leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      else
         leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
   endfunction

   function automatic logic [7:0] days_in_month(input logic [7:0] m,
                                                 input logic       leap);
      case (m)
         8'h02:   days_in_month = leap ? 8'h29 : 8'h28;
         8'h04,
         8'h06,
         8'h09,
         8'h11:   days_in_month = 8'h30;
         default: days_in_month = 8'h31;
      endcase
   endfunction

endpackage
